// file: verilog/ep_cfg_defs.svh
// Offsets, field positions and reset values of the endpoint config block
`ifndef EP_CFG_DEFS_SVH
`define EP_CFG_DEFS_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_OUT_CFG    12'h000
`define OFS_OUT_LIMIT  12'h004
`define OFS_IRQ_STAT   12'h010
`define OFS_IRQ_EN     12'h014
`define OFS_IRQ_CLR    12'h018
`define OFS_IN_BASE    12'h100
`define IN_GRP_SHIFT   5
`define IN_WORD_CNT    3'h0
`define IN_WORD_BASE   3'h1
`define IN_WORD_MODE   3'h2
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_EN         7
`define BIT_ISO        6
`define BIT_OVF        5
`define BIT_EMPTY      7
`define IRQ_OVF        0
`define IRQ_EMPTY      1
// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define IN_EP_NUM      7
`define GRP_BYTES      8
`define RST_BYTE       8'h00
`define RST_IRQ        2'h0
`define LSB_ZERO       3'h0
`define CNT_ONE        11'h001
`define BPS_ONE        6'h01
`endif

// file: verilog/ep_cfg_pkg.sv
// Types shared by the endpoint config block and its users
package ep_cfg_pkg;
   // In token from the serial engine
   typedef struct packed {
      logic       valid;
      logic [2:0] ep;
   } in_req_t;
   // Answer to an in token
   typedef struct packed {
      logic        valid;
      logic        nak;
      logic        iso;
      logic [12:0] bytes;
      logic [10:0] addr;
   } in_rsp_t;
   // Out packet byte stream
   typedef struct packed {
      logic start;
      logic byte_v;
   } out_evt_t;
endpackage

// file: verilog/usb_endpoint_buffer_config.sv
// Endpoint configuration bytes, APB slave and in/out buffer control
`timescale 1ns/1ps
// What this block does
// - Enable bit 7 activates the out endpoint
// - Bit 6 selects isochronous or other types
// - Overflow sets bit 5, diagnostics only
// - Only a software zero clears overflow
// - Bytes per sample is field plus one
// - Each in endpoint owns a 32-byte group of eight words
// - Seven in endpoints beside the control one
// - Successful Y in transaction sets empty flag
// - Empty flag makes non-iso endpoints NAK
// - Isochronous endpoints never NAK
// - Non-iso count means bytes
// - Iso count means samples times size
// - Base byte gives address bits 10:3
// - Low three address bits are zero
`include "ep_cfg_defs.svh"
module usb_endpoint_buffer_config (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Serial engine, in side
   input  wire ep_cfg_pkg::in_req_t in_req,
   input  wire logic               in_done,
   input  wire logic [2:0]         in_done_ep,
   output ep_cfg_pkg::in_rsp_t     in_rsp,
   // Serial engine, out side
   input  wire ep_cfg_pkg::out_evt_t out_evt,
   output logic                    out_active,
   output logic                    out_iso,
   output logic                    out_keep,
   output logic [10:0]             out_ofs,
   // Interrupt
   output logic                    irq
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0]  out_cfg_q;                  // Out iso config byte
   logic [7:0]  out_lim_q;                  // Out space, 8-byte units
   logic [7:0]  ycnt_q [`IN_EP_NUM];        // Y count bytes
   logic [7:0]  ybase_q [`IN_EP_NUM];       // Y base bytes
   logic [7:0]  mode_q [`IN_EP_NUM];        // In mode bytes
   logic [1:0]  stat_q;                     // Sticky events
   logic [1:0]  en_q;                       // Event enables
   logic [10:0] ocnt_q;                     // Out bytes taken
   logic [31:0] rdata_d;                    // Read mux
   logic        unmapped;                   // Decode miss
   logic        wr_acc;                     // Write takes effect
   logic        ovf_ev;                     // Overflow this cycle
   logic        empty_ev;                   // Empty set this cycle
   logic [2:0]  grp;                        // In group index
   logic [2:0]  word;                       // Word within group
   logic        in_grp;                     // Address in in area
   logic [11:0] space;                      // Out space in bytes

   assign wr_acc = psel && penable && pready && pwrite;
   assign grp    = 3'(paddr[10:`IN_GRP_SHIFT] - 6'h08);
   assign word   = paddr[4:2];
   assign in_grp = paddr[11:8] == 4'h1 &&
                   paddr[7:`IN_GRP_SHIFT] < 3'(`IN_EP_NUM);
   assign space  = {1'b0, out_lim_q, `LSB_ZERO};

   // ----------------------------------------------------------------
   // APB read decode
   // ----------------------------------------------------------------
   // Reserved bits and unused group words read zero
   always_comb begin
      rdata_d  = 32'h0;
      unmapped = 1'b0;
      if (in_grp) begin
         unique case (word)
            `IN_WORD_CNT:  rdata_d[7:0] = ycnt_q[grp];
            `IN_WORD_BASE: rdata_d[7:0] = ybase_q[grp];
            `IN_WORD_MODE: rdata_d[7:0] = mode_q[grp];
            default:       rdata_d = 32'h0;
         endcase
      end else begin
         unique case (paddr)
            `OFS_OUT_CFG:   rdata_d[7:0] = out_cfg_q;
            `OFS_OUT_LIMIT: rdata_d[7:0] = out_lim_q;
            `OFS_IRQ_STAT:  rdata_d[1:0] = stat_q;
            `OFS_IRQ_EN:    rdata_d[1:0] = en_q;
            `OFS_IRQ_CLR:   rdata_d = 32'h0;
            default:        unmapped = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB handshake: no wait state, answer in the first access cycle
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel && !penable && !pready;
         pslverr <= psel && !penable && !pready && unmapped;
         if (psel && !penable)
            prdata <= pwrite ? 32'h0 : rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Out config byte and space register
   // ----------------------------------------------------------------
   // Set from hardware wins over a software clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_cfg_q <= `RST_BYTE;
         out_lim_q <= `RST_BYTE;
      end else begin
         if (wr_acc && paddr == `OFS_OUT_CFG) begin
            out_cfg_q <= pwdata[7:0];
            // Writing one keeps the flag, zero clears it
            out_cfg_q[`BIT_OVF] <= ovf_ev ||
               (out_cfg_q[`BIT_OVF] && pwdata[`BIT_OVF]);
         end else if (ovf_ev) begin
            out_cfg_q[`BIT_OVF] <= 1'b1;
         end
         if (wr_acc && paddr == `OFS_OUT_LIMIT)
            out_lim_q <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Out byte stream: count, and in iso mode discard past the space
   // ----------------------------------------------------------------
   assign ovf_ev = out_evt.byte_v && out_cfg_q[`BIT_EN] &&
                   out_cfg_q[`BIT_ISO] &&
                   {1'b0, ocnt_q} >= space;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ocnt_q   <= 11'h0;
         out_keep <= 1'b0;
         out_ofs  <= 11'h0;
      end else begin
         out_keep <= 1'b0;
         if (out_evt.start) begin
            ocnt_q <= 11'h0;
         end else if (out_evt.byte_v && out_cfg_q[`BIT_EN] &&
                      !ovf_ev) begin
            // Excess bytes are dropped, not written
            out_keep <= 1'b1;
            out_ofs  <= ocnt_q;
            ocnt_q   <= ocnt_q + `CNT_ONE;
         end
      end
   end

   // Endpoint state seen by the serial engine
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_active <= 1'b0;
         out_iso    <= 1'b0;
      end else begin
         out_active <= out_cfg_q[`BIT_EN];
         out_iso    <= out_cfg_q[`BIT_ISO];
      end
   end

   // ----------------------------------------------------------------
   // In endpoint groups, one per endpoint 1 to 7
   // ----------------------------------------------------------------
   assign empty_ev = in_done && in_done_ep != 3'h0;

   // Group registers; empty set wins over a write
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `IN_EP_NUM; i++) begin
            ycnt_q[i]  <= `RST_BYTE;
            ybase_q[i] <= `RST_BYTE;
            mode_q[i]  <= `RST_BYTE;
         end
      end else begin
         if (wr_acc && in_grp) begin
            unique case (word)
               `IN_WORD_CNT:  ycnt_q[grp]  <= pwdata[7:0];
               `IN_WORD_BASE: ybase_q[grp] <= pwdata[7:0];
               `IN_WORD_MODE: mode_q[grp]  <= pwdata[7:0];
               default:       ;
            endcase
         end
         if (empty_ev)
            ycnt_q[3'(in_done_ep - 3'h1)][`BIT_EMPTY] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // In token answer, one cycle after the token
   // ----------------------------------------------------------------
   logic [2:0]  rix;                        // Endpoint array index
   logic [7:0]  rcnt;                       // Its count byte
   logic [7:0]  rmode;                      // Its mode byte
   logic [12:0] iso_bytes;                  // Samples times size
   assign rix   = 3'(in_req.ep - 3'h1);
   assign rcnt  = ycnt_q[rix];
   assign rmode = mode_q[rix];
   assign iso_bytes = 13'({6'h0, rcnt[6:0]} *
                          ({1'b0, rmode[4:0]} + `BPS_ONE));

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         in_rsp <= '0;
      end else begin
         in_rsp.valid <= in_req.valid;
         if (in_req.valid) begin
            if (in_req.ep == 3'h0) begin
               // Control endpoint is served elsewhere
               in_rsp.nak   <= 1'b1;
               in_rsp.iso   <= 1'b0;
               in_rsp.bytes <= 13'h0;
               in_rsp.addr  <= 11'h0;
            end else begin
               in_rsp.iso <= rmode[`BIT_ISO];
               // Iso never NAKs; others NAK while empty
               in_rsp.nak <= !rmode[`BIT_ISO] &&
                             rcnt[`BIT_EMPTY];
               in_rsp.bytes <= rmode[`BIT_ISO] ? iso_bytes
                               : {6'h0, rcnt[6:0]};
               in_rsp.addr <= {ybase_q[rix], `LSB_ZERO};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, enable and clear
   // ----------------------------------------------------------------
   // Sticky events; a new event wins over its clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stat_q <= `RST_IRQ;
         en_q   <= `RST_IRQ;
         irq    <= 1'b0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if ((b == `IRQ_OVF && ovf_ev) ||
                (b == `IRQ_EMPTY && empty_ev))
               stat_q[b] <= 1'b1;
            else if (wr_acc && paddr == `OFS_IRQ_CLR && pwdata[b])
               stat_q[b] <= 1'b0;
         end
         if (wr_acc && paddr == `OFS_IRQ_EN)
            en_q <= pwdata[1:0];
         irq <= |(stat_q & en_q);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_ovf_set;
      @(posedge core_clk) disable iff (!rst_n)
      ovf_ev |=> out_cfg_q[`BIT_OVF];
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow flag not set");

   property p_ovf_hold;
      @(posedge core_clk) disable iff (!rst_n)
      out_cfg_q[`BIT_OVF] && !(wr_acc && paddr == `OFS_OUT_CFG)
      |=> out_cfg_q[`BIT_OVF];
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("overflow flag cleared by hardware");

   property p_drop;
      @(posedge core_clk) disable iff (!rst_n)
      ovf_ev |=> !out_keep;
   endproperty
   a_drop: assert property (p_drop)
      else $error("excess byte kept");

   property p_active;
      @(posedge core_clk) disable iff (!rst_n)
      ##1 out_active == $past(out_cfg_q[`BIT_EN]);
   endproperty
   a_active: assert property (p_active)
      else $error("out active mismatch");

   property p_empty;
      @(posedge core_clk) disable iff (!rst_n)
      empty_ev |=> ycnt_q[3'($past(in_done_ep) - 3'h1)][`BIT_EMPTY];
   endproperty
   a_empty: assert property (p_empty)
      else $error("empty flag not set");

   property p_nak;
      @(posedge core_clk) disable iff (!rst_n)
      in_req.valid && in_req.ep != 3'h0 && !rmode[`BIT_ISO] &&
      rcnt[`BIT_EMPTY] |=> in_rsp.valid && in_rsp.nak;
   endproperty
   a_nak: assert property (p_nak)
      else $error("empty endpoint not NAKed");

   property p_iso_nonak;
      @(posedge core_clk) disable iff (!rst_n)
      in_rsp.valid && in_rsp.iso |-> !in_rsp.nak;
   endproperty
   a_iso_nonak: assert property (p_iso_nonak)
      else $error("iso endpoint NAKed");

   property p_addr;
      @(posedge core_clk) disable iff (!rst_n)
      in_rsp.valid |-> in_rsp.addr[2:0] == `LSB_ZERO;
   endproperty
   a_addr: assert property (p_addr)
      else $error("buffer address not aligned");

   property p_bytes;
      @(posedge core_clk) disable iff (!rst_n)
      in_req.valid && in_req.ep != 3'h0 && !rmode[`BIT_ISO]
      |=> in_rsp.bytes == 13'($past(rcnt[6:0]));
   endproperty
   a_bytes: assert property (p_bytes)
      else $error("byte count mismatch");

   c_nak:   cover property (@(posedge core_clk) in_rsp.valid &&
                            in_rsp.nak);
   c_iso:   cover property (@(posedge core_clk) in_rsp.valid &&
                            in_rsp.iso && in_rsp.bytes != 13'h0);
   c_ovf:   cover property (@(posedge core_clk) ovf_ev);
   c_irq:   cover property (@(posedge core_clk) irq);
endmodule

// file: testbench/sie_model.sv
// Serial engine stand-in: in tokens, done pulses, out packets
`timescale 1ns/1ps
module sie_model (
   // Clock
   input  wire logic            core_clk,
   // Traffic toward the block
   output ep_cfg_pkg::in_req_t  in_req,
   output logic                 in_done,
   output logic [2:0]           in_done_ep,
   output ep_cfg_pkg::out_evt_t out_evt
);
   // ----------------------------------------------------------------
   // Idle state and traffic tasks
   // ----------------------------------------------------------------
   // Nothing pending at time zero
   initial begin
      in_req = '0;
      in_done = 1'b0;
      in_done_ep = 3'h0;
      out_evt = '0;
   end
   // One-cycle token; released endpoint lines show the inverse
   task automatic token(input logic [2:0] ep);
      @(posedge core_clk);
      in_req <= '{valid: 1'b1, ep: ep};
      @(posedge core_clk);
      in_req <= '{valid: 1'b0, ep: ~ep};
   endtask
   // Successful in transaction from the Y buffer
   task automatic done(input logic [2:0] ep);
      @(posedge core_clk);
      in_done <= 1'b1;
      in_done_ep <= ep;
      @(posedge core_clk);
      in_done <= 1'b0;
      in_done_ep <= ~ep;
   endtask
   // Start, then n bytes back to back
   task automatic packet(input int n);
      @(posedge core_clk);
      out_evt <= '{start: 1'b1, byte_v: 1'b0};
      @(posedge core_clk);
      out_evt <= '{start: 1'b0, byte_v: 1'b1};
      repeat (n) @(posedge core_clk);
      out_evt <= '0;
   endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the endpoint config block
`timescale 1ns/1ps
`include "ep_cfg_defs.svh"
module testbench;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic                 core_clk = 1'b0; // 200 MHz clock
   logic                 rst_n    = 1'b0; // Sync reset, low active
   logic                 psel     = 1'b0; // APB request
   logic                 penable  = 1'b0;
   logic                 pwrite   = 1'b0;
   logic [11:0]          paddr    = 12'h000;
   logic [31:0]          pwdata   = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   ep_cfg_pkg::in_req_t  in_req;   // From the engine model
   logic                 in_done;
   logic [2:0]           in_done_ep;
   ep_cfg_pkg::in_rsp_t  in_rsp;
   ep_cfg_pkg::out_evt_t out_evt;
   logic                 out_active;
   logic                 out_iso;
   logic                 out_keep;
   logic [10:0]          out_ofs;
   logic                 irq;
   int                   num_errors = 0; // Mismatch count
   int                   checks     = 0; // Comparison count
   int                   keep_n     = 0; // Kept bytes seen
   // Half-period toggle
   always #2.5 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   usb_endpoint_buffer_config u_usb_endpoint_buffer_config (
      .core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_req(in_req), .in_done(in_done),
      .in_done_ep(in_done_ep), .in_rsp(in_rsp), .out_evt(out_evt),
      .out_active(out_active), .out_iso(out_iso),
      .out_keep(out_keep), .out_ofs(out_ofs), .irq(irq));
   sie_model u_sie_model (
      .core_clk(core_clk), .in_req(in_req), .in_done(in_done),
      .in_done_ep(in_done_ep), .out_evt(out_evt));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Compare seen against expected
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer, held until pready at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   // Register write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   // Register read and compare
   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(nm, r, x);
   endtask
   // Byte address of word w of in endpoint n
   function automatic logic [11:0] ga(input int n, input int w);
      return `OFS_IN_BASE + 12'((n - 1) << `IN_GRP_SHIFT) + 12'(w * 4);
   endfunction
   // Wait for the token answer and compare its fields
   task automatic rsp_chk(input int nak, input int iso, input int by,
                          input int ad);
      int i;
      for (i = 0; i < 4; i++) begin
         #1;
         if (in_rsp.valid === 1'b1) break;
         @(posedge core_clk);
      end
      if (i == 4) begin
         num_errors++;
         report_and_stop();
      end
      check("nak", in_rsp.nak, nak);
      check("iso", in_rsp.iso, iso);
      check("bytes", in_rsp.bytes, by);
      check("addr", in_rsp.addr, ad);
   endtask
   // Kept bytes come in arrival order from offset 0
   always @(posedge core_clk) begin
      if (out_keep === 1'b1) begin
         check("ofs", out_ofs, keep_n);
         keep_n++;
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int n, c, b, m, iso, by, k, cfg, ovf, nkeep, bps;
      logic [31:0] rd;
      logic        er;
      void'($urandom(33255));
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rdc("cfg", `OFS_OUT_CFG, 0);
      rdc("stat", `OFS_IRQ_STAT, 0);
      $display("test reset done");
      // Every in endpoint group, random count, base and mode
      for (n = 1; n <= `IN_EP_NUM; n++) begin
         c = $urandom_range(127, 0);
         b = $urandom_range(255, 0);
         m = $urandom_range(255, 0) & 8'h5f;
         iso = m >> 6;
         by = iso ? c * ((m & 31) + 1) : c;
         wr(ga(n, 0), c);
         wr(ga(n, 1), b);
         wr(ga(n, 2), m);
         rdc("base", ga(n, 1), b);
         rdc("spare", ga(n, 3), 0);
         u_sie_model.token(3'(n));
         rsp_chk(0, iso, by, b * 8);
         u_sie_model.done(3'(n));
         rdc("count", ga(n, 0), c | 128);
         u_sie_model.token(3'(n));
         rsp_chk(!iso, iso, by, b * 8);
         wr(ga(n, 0), c);
         u_sie_model.token(3'(n));
         rsp_chk(0, iso, by, b * 8);
      end
      // Control endpoint token is refused with a NAK
      u_sie_model.token(3'h0);
      rsp_chk(1, 0, 0, 0);
      // No eighth group: error response, data zero
      apb(1'b0, ga(8, 0), 32'h0, rd, er);
      check("slverr", er, 1);
      check("unmapped", rd, 0);
      // Spare group words are mapped, no error
      apb(1'b0, ga(1, 3), 32'h0, rd, er);
      check("slverr", er, 0);
      check("irq", irq, 0);
      rdc("stat", `OFS_IRQ_STAT, 2);
      wr(`OFS_IRQ_CLR, 3);
      rdc("stat", `OFS_IRQ_STAT, 0);
      rdc("clr", `OFS_IRQ_CLR, 0);
      $display("test in endpoints done");
      // Disabled, bulk and isochronous out with a 8-byte space
      wr(`OFS_OUT_LIMIT, 1);
      wr(`OFS_IRQ_EN, 1);
      bps = $urandom_range(31, 0);
      for (k = 0; k < 3; k++) begin
         cfg = (k == 0) ? 0 : (k == 1) ? 8'h80 : 8'hc0 | bps;
         nkeep = (k == 0) ? 0 : (k == 1) ? 10 : 8;
         ovf = (k == 2);
         wr(`OFS_OUT_CFG, cfg);
         rdc("cfg", `OFS_OUT_CFG, cfg);
         @(posedge core_clk);
         #1;
         check("active", out_active, k > 0);
         check("out_iso", out_iso, ovf);
         keep_n = 0;
         u_sie_model.packet(10);
         repeat (3) @(posedge core_clk);
         check("keeps", keep_n, nkeep);
         rdc("cfg", `OFS_OUT_CFG, cfg | (ovf << 5));
         check("irq", irq, ovf);
      end
      rdc("stat", `OFS_IRQ_STAT, 1);
      wr(`OFS_OUT_CFG, 8'he0 | bps);
      rdc("cfg", `OFS_OUT_CFG, 8'he0 | bps);
      wr(`OFS_OUT_CFG, 8'hc0 | bps);
      rdc("cfg", `OFS_OUT_CFG, 8'hc0 | bps);
      wr(`OFS_OUT_CFG, 8'he0 | bps);
      rdc("cfg", `OFS_OUT_CFG, 8'hc0 | bps);
      wr(`OFS_IRQ_CLR, 1);
      repeat (2) @(posedge core_clk);
      #1;
      check("irq", irq, 0);
      $display("test out stream done");
      report_and_stop();
   end
endmodule
